// *** hw/rbs_addr_form.sv ***
module rbs_addr_form
    import rbs_pkg::*;
(
    // Operand
    input wire logic [7:0] file_addr,
    input wire logic use_bank_sel,
    // Core state
    input wire logic [BANK_W-1:0] bank_sel,
    input wire logic [DADDR_W-1:0] idx_base,
    input wire logic ext_set_en,
    // Result
    output logic [DADDR_W-1:0] data_addr,
    output logic indexed
);
    logic [DADDR_W-1:0] acc_addr;
    logic [DADDR_W-1:0] banked_addr;
    logic [DADDR_W-1:0] idx_addr;

    // Access addresses up to 95 map to bank 0, addresses 96 and up to the top SFR bank
    assign acc_addr = (file_addr <= ACC_LOW_LAST) ? {ACC_LOW_BANK, file_addr} : {ACC_HIGH_BANK, file_addr};
    assign banked_addr = {bank_sel, file_addr};
    assign idx_addr = idx_base + {4'h0, file_addr};
    assign indexed = !use_bank_sel && ext_set_en && (file_addr <= IDX_LIT_LAST); // [RQ7]
    assign data_addr = use_bank_sel ? banked_addr // [RQ6]
                     : indexed ? idx_addr // [RQ7]
                     : acc_addr; // [RQ5]
endmodule

// *** hw/rbs_exec.sv ***
// Summary of operation
// RQ1 - An opcode with top five bits 11010 is the unconditional jump, its low 11 bits a signed offset -1024..1023.
// RQ2 - The jump target is the incremented program counter plus twice the signed offset.
// RQ3 - The jump takes two instruction cycles, loads the counter in the first Q4 and does nothing in the second.
// RQ4 - An opcode with top nibble 1000 is the bit set, with a 3-bit index, an access bit and an 8-bit address.
// RQ5 - With the access bit clear the address is resolved inside the access bank.
// RQ6 - With the access bit set the address is the bank select register joined to the 8-bit address.
// RQ7 - With the access bit clear, the extended set on and an address up to 95, indexed literal offset is used.
// RQ8 - The bit set reads in Q2 and writes back in Q4 of one cycle, and neither instruction touches status flags.
module rbs_exec
    import rbs_pkg::*;
(
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RSTN,
    // Fetch side
    input wire logic [INSTR_W-1:0] INSTR,
    input wire logic INSTR_VALID,
    input wire logic [PC_W-1:0] PC_IN,
    // Core state
    input wire logic [BANK_W-1:0] BANK_SELECT_REG,
    input wire logic [DADDR_W-1:0] IDX_BASE,
    input wire logic EXT_SET_EN,
    // Program counter load
    output logic PC_LOAD,
    output logic [PC_W-1:0] PC_TARGET,
    // Forced no-operation cycle, prefetched word discarded
    output logic NOP_CYCLE,
    output logic [1:0] PHASE,
    // Data memory
    output logic [DADDR_W-1:0] DM_ADDR,
    output logic DM_RD,
    input wire logic [7:0] DM_RDATA,
    output logic DM_WR,
    output logic [7:0] DM_WDATA,
    // Status flag write, never used by these instructions
    output logic STATUS_WE
);
    rbs_phase_t phase_ff;
    rbs_phase_t nxt_phase;
    logic [INSTR_W-1:0] ir_ff;
    logic jump_ff;
    logic set_ff;
    logic nop_ff;
    logic [PC_W-1:0] target_ff;
    logic [DADDR_W-1:0] addr_ff;
    logic [7:0] wdata_ff;

    logic take;
    logic dec_jump;
    logic dec_set;
    logic [PC_W-1:0] offs_x2;
    logic [PC_W-1:0] nxt_target;
    logic [DADDR_W-1:0] nxt_addr;
    logic [7:0] set_mask;
    logic start_jump;
    logic start_set;
    logic nxt_indexed;

    function automatic logic [7:0] bit_mask(input logic [2:0] idx);
        bit_mask = 8'h01 << idx;
    endfunction

    // A word offered in Q1 of the no-op cycle is the discarded prefetch
    assign take = (phase_ff == RBS_Q1) && INSTR_VALID && !nop_ff; // [RQ3]
    assign dec_jump = INSTR[INSTR_W-1:OPC_JUMP_LSB] == OPC_REL_JUMP; // [RQ1]
    assign dec_set = INSTR[INSTR_W-1:OPC_SET_LSB] == OPC_BIT_SET; // [RQ4]
    assign start_jump = take && dec_jump; // [RQ1]
    assign start_set = take && dec_set; // [RQ4]
    // Sign extend the 11-bit offset and double it
    assign offs_x2 = {{(PC_W-OFFS_W-1){INSTR[OFFS_W-1]}}, INSTR[OFFS_W-1:0], 1'b0}; // [RQ1]
    assign nxt_target = PC_IN + offs_x2; // [RQ2]
    assign set_mask = bit_mask(ir_ff[BIT_IDX_LSB +: 3]); // [RQ4]

    always_comb begin
        unique case (phase_ff)
            RBS_Q1: nxt_phase = RBS_Q2;
            RBS_Q2: nxt_phase = RBS_Q3;
            RBS_Q3: nxt_phase = RBS_Q4;
            RBS_Q4: nxt_phase = RBS_Q1;
        endcase
    end

    rbs_addr_form u_addr (
        .file_addr(INSTR[FILE_ADDR_LSB +: 8]),
        .use_bank_sel(INSTR[ACC_BIT_POS]),
        .bank_sel(BANK_SELECT_REG),
        .idx_base(IDX_BASE),
        .ext_set_en(EXT_SET_EN),
        .data_addr(nxt_addr),
        .indexed(nxt_indexed)
    );

    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            phase_ff <= RBS_Q1;
        end else begin
            phase_ff <= nxt_phase;
        end
    end

    // Operands are captured at Q1 so that later bank or index changes cannot tear an access
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            ir_ff <= INSTR_RST;
        end else if (phase_ff == RBS_Q1) begin
            ir_ff <= INSTR;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            jump_ff <= 1'b0;
            set_ff <= 1'b0;
        end else if (phase_ff == RBS_Q1) begin
            jump_ff <= start_jump; // [RQ1]
            set_ff <= start_set; // [RQ4]
        end
    end

    // Target stays put until the next jump, so the core may pick it up any time after Q1
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            target_ff <= PC_TARGET_RST;
        end else if (start_jump) begin
            target_ff <= nxt_target; // [RQ2]
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            addr_ff <= DADDR_RST;
        end else if (start_set) begin
            addr_ff <= nxt_addr; // [RQ5] [RQ6] [RQ7]
        end
    end

    // Second jump cycle: the prefetched word is dropped and nothing runs
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            nop_ff <= 1'b0;
        end else if (phase_ff == RBS_Q4) begin
            nop_ff <= jump_ff; // [RQ3]
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            wdata_ff <= 8'h00;
        end else if (phase_ff == RBS_Q2 && set_ff) begin
            wdata_ff <= DM_RDATA | set_mask; // [RQ4]
        end
    end

    assign PC_LOAD = jump_ff && (phase_ff == RBS_Q4); // [RQ3]
    assign PC_TARGET = target_ff;
    assign NOP_CYCLE = nop_ff;
    assign PHASE = phase_ff;
    assign DM_ADDR = addr_ff;
    assign DM_RD = set_ff && (phase_ff == RBS_Q2); // [RQ8]
    assign DM_WR = set_ff && (phase_ff == RBS_Q4); // [RQ8]
    assign DM_WDATA = wdata_ff;
    assign STATUS_WE = 1'b0; // [RQ8]

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RSTN);

    // Jump and its no-op cycle
    a_jump_decode: assert property ((phase_ff == RBS_Q1) && INSTR_VALID && !nop_ff // [RQ1]
        && INSTR[15:11] == 5'h1a |-> ##3 PC_LOAD) else $error("jump opcode did not load the counter");
    a_jump_target: assert property (PC_LOAD |-> PC_TARGET == // [RQ2]
        $past(PC_IN, 3) + {{9{$past(INSTR[10], 3)}}, $past(INSTR[10:0], 3), 1'b0})
        else $error("jump target wrong");
    a_jump_nop: assert property (PC_LOAD |=> NOP_CYCLE [*4] ##1 !NOP_CYCLE) // [RQ3]
        else $error("jump second cycle not a single no-op cycle");
    a_nop_idle: assert property (NOP_CYCLE |-> !DM_RD && !DM_WR && !PC_LOAD) // [RQ3]
        else $error("activity during no-op cycle");
    a_bit11_jump: assert property ((phase_ff == RBS_Q1) && INSTR_VALID && !nop_ff // [RQ1]
        && INSTR[15:11] == 5'h1b |-> ##3 !PC_LOAD)
        else $error("opcode with bit 11 set loaded the counter");
    a_nop_discard: assert property (NOP_CYCLE && (phase_ff == RBS_Q1) // [RQ3]
        |=> !jump_ff && !set_ff)
        else $error("word fetched in the no-op cycle was executed");
    a_load_once: assert property (PC_LOAD // [RQ3]
        |=> !PC_LOAD [*7])
        else $error("counter loaded again inside the jump");

    // Bit set addressing and write-back
    a_set_value: assert property (DM_WR |-> DM_WDATA == // [RQ4]
        ($past(DM_RDATA, 2) | (8'h01 << $past(INSTR[11:9], 3)))) else $error("bit set wrote wrong value");
    a_access_bank: assert property (DM_RD && !$past(INSTR[8]) && !($past(EXT_SET_EN) && // [RQ5]
        $past(INSTR[7:0]) <= 8'h5f) |-> DM_ADDR[7:0] == $past(INSTR[7:0])
        && (DM_ADDR[11:8] == (($past(INSTR[7:0]) <= 8'h5f) ? 4'h0 : 4'hf))) else $error("access bank address wrong");
    a_bank_select: assert property (DM_RD && $past(INSTR[8]) |-> // [RQ6]
        DM_ADDR == {$past(BANK_SELECT_REG), $past(INSTR[7:0])}) else $error("banked address wrong");
    a_indexed_mode: assert property (DM_RD && !$past(INSTR[8]) && $past(EXT_SET_EN) && // [RQ7]
        $past(INSTR[7:0]) <= 8'h5f |-> DM_ADDR == $past(IDX_BASE) + {4'h0, $past(INSTR[7:0])})
        else $error("indexed literal address wrong");
    a_read_write: assert property (DM_RD |-> ##2 DM_WR && $stable(DM_ADDR) && !STATUS_WE) // [RQ8]
        else $error("bit set write-back not in Q4");
    a_wdata_hold: assert property (DM_WR // [RQ8]
        |-> $stable(DM_WDATA) && $past(DM_RD, 2))
        else $error("write-back data or read missing before the write");
    a_operand_hold: assert property ((phase_ff != RBS_Q1) // [RQ2] [RQ5]
        |=> $stable(PC_TARGET) && $stable(DM_ADDR))
        else $error("captured operand changed mid-cycle");

    // Cycle framing
    a_stray_opcode: assert property ((phase_ff == RBS_Q1) && INSTR[15:12] != 4'h8 // [RQ1] [RQ4]
        && INSTR[15:11] != 5'h1a |=> !DM_RD ##2 !DM_WR && !PC_LOAD)
        else $error("unknown opcode caused activity");
    a_phase_walk: assert property (PHASE == 2'h3 // [RQ8]
        |=> PHASE == 2'h0 ##1 PHASE == 2'h1 ##1 PHASE == 2'h2 ##1 PHASE == 2'h3)
        else $error("instruction cycle not four clocks");
    a_reset_quiet: assert property (disable iff (1'b0) !RSTN // [RQ3] [RQ8]
        |=> PHASE == 2'h0 && !PC_LOAD && !NOP_CYCLE && !DM_RD && !DM_WR)
        else $error("outputs not idle after reset");

    // Main scenarios
    c_jump: cover property (PC_LOAD ##1 NOP_CYCLE [*4] ##1 !NOP_CYCLE);
    c_set_banked: cover property (DM_WR && addr_ff[11:8] != 4'h0);
    c_set_indexed: cover property (start_set && nxt_indexed ##1 DM_RD ##2 DM_WR);
    c_set_access: cover property (start_set && !INSTR[ACC_BIT_POS] && !nxt_indexed ##1 DM_RD ##2 DM_WR);
    c_nop_discard: cover property (NOP_CYCLE && (phase_ff == RBS_Q1) && INSTR_VALID);
endmodule

// *** hw/rbs_pkg.sv ***
package rbs_pkg;
    // Instruction fields
    localparam int INSTR_W = 16;
    localparam int PC_W = 21;
    localparam int DADDR_W = 12;
    localparam int BANK_W = 4;
    localparam int OFFS_W = 11;
    localparam logic [4:0] OPC_REL_JUMP = 5'h1a;
    localparam logic [3:0] OPC_BIT_SET = 4'h8;
    localparam int OPC_JUMP_LSB = 11;
    localparam int OPC_SET_LSB = 12;
    localparam int BIT_IDX_LSB = 9;
    localparam int ACC_BIT_POS = 8;
    localparam int FILE_ADDR_LSB = 0;

    // Access bank split and indexed-literal window
    localparam logic [7:0] ACC_LOW_LAST = 8'h5f;
    localparam logic [7:0] IDX_LIT_LAST = 8'h5f;
    localparam logic [BANK_W-1:0] ACC_LOW_BANK = 4'h0;
    localparam logic [BANK_W-1:0] ACC_HIGH_BANK = 4'hf;

    // Reset values
    localparam logic [PC_W-1:0] PC_TARGET_RST = 21'h000000;
    localparam logic [DADDR_W-1:0] DADDR_RST = 12'h000;
    localparam logic [INSTR_W-1:0] INSTR_RST = 16'h0000;

    // One instruction cycle is four clocks, one per phase
    typedef enum logic [1:0] {
        RBS_Q1,
        RBS_Q2,
        RBS_Q3,
        RBS_Q4
    } rbs_phase_t;
endpackage

// *** testbench/rbs_dmem_model.sv ***
module rbs_dmem_model
    import rbs_pkg::*;
(
    // Clock
    input wire logic CLOCK,
    // Data memory
    input wire logic [DADDR_W-1:0] DM_ADDR,
    input wire logic DM_RD,
    input wire logic DM_WR,
    input wire logic [7:0] DM_WDATA,
    output logic [7:0] DM_RDATA
);
    logic [7:0] mem [0:4095];
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 8'(i * 7);
        end
    end
    // Outside a read the bus shows the inverse, so a late sample never looks right
    assign DM_RDATA = DM_RD ? mem[DM_ADDR] : ~mem[DM_ADDR];
    always @(posedge CLOCK) begin
        if (DM_WR) begin
            mem[DM_ADDR] <= DM_WDATA;
        end
    end
endmodule

// *** testbench/relative_branch_bit_set_exec_test.sv ***
module relative_branch_bit_set_exec_test
    import rbs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0, rstn = 1'b0, instr_valid = 1'b0, ext_set_en = 1'b0;
    logic [INSTR_W-1:0] instr = 16'h0000;
    logic [PC_W-1:0] pc_in = 21'h000000, pc_target;
    logic [BANK_W-1:0] bank_select_reg = 4'h0;
    logic [DADDR_W-1:0] idx_base = 12'hff8, dm_addr, addr;
    logic [7:0] dm_rdata, dm_wdata;
    logic [1:0] phase;
    logic pc_load, nop_cycle, dm_rd, dm_wr, status_we;
    logic [2:0] rdv, wrv, plv, nopv;
    int failures = 0, compares = 0;
    always #12.5 clock = ~clock;
    rbs_exec dut (.CLOCK(clock), .RSTN(rstn), .INSTR(instr), .INSTR_VALID(instr_valid), .PC_IN(pc_in),
        .BANK_SELECT_REG(bank_select_reg), .IDX_BASE(idx_base), .EXT_SET_EN(ext_set_en), .PC_LOAD(pc_load),
        .PC_TARGET(pc_target), .NOP_CYCLE(nop_cycle), .PHASE(phase), .DM_ADDR(dm_addr), .DM_RD(dm_rd),
        .DM_RDATA(dm_rdata), .DM_WR(dm_wr), .DM_WDATA(dm_wdata), .STATUS_WE(status_we));
    rbs_dmem_model dm (.CLOCK(clock), .DM_ADDR(dm_addr), .DM_RD(dm_rd), .DM_WR(dm_wr), .DM_WDATA(dm_wdata),
        .DM_RDATA(dm_rdata));
    task chk(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            failures++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    // Presents one word in Q1 and records Q2..Q4
    task run(input logic [15:0] w, input logic [20:0] pc, input logic [3:0] bank, input logic ext);
        do @(negedge clock); while (phase !== 2'h0);
        instr = w;
        pc_in = pc;
        bank_select_reg = bank;
        ext_set_en = ext;
        instr_valid = 1'b1;
        for (int k = 0; k < 3; k++) begin
            @(negedge clock);
            instr_valid = 1'b0;
            rdv[k] = dm_rd;
            wrv[k] = dm_wr;
            plv[k] = pc_load;
            nopv[k] = nop_cycle;
            if (k == 0) begin
                addr = dm_addr;
            end
            chk(status_we === 1'b0, "status flag written");
            chk(phase === 2'(k + 1), "phase out of order");
        end
    endtask
    task jmp(input logic [10:0] off, input logic [20:0] pc);
        logic [20:0] exp;
        exp = pc + {{9{off[10]}}, off, 1'b0};
        run({5'h1a, off}, pc, 4'h0, 1'b0);
        chk(pc_target === exp, "jump target");
        chk(plv === 3'b100 && rdv === 3'b000, "jump load phase");
        run(16'h8fff, pc, 4'h3, 1'b0);
        chk(nopv === 3'b111 && (plv | rdv | wrv) === 3'b000, "second cycle not idle");
    endtask
    task bset(input logic [2:0] b, input logic a, input logic [7:0] f, input logic [3:0] bank, input logic ext,
        input logic [11:0] exp);
        logic [7:0] old;
        old = dm.mem[exp];
        run({4'h8, b, a, f}, 21'h000040, bank, ext);
        chk(addr === exp, "bit set address");
        chk(rdv === 3'b001 && wrv === 3'b100, "bit set phases");
        @(posedge clock);
        #1;
        chk(dm.mem[exp] === (old | (8'h01 << b)), "bit set data");
    endtask
    // A word offered in Q1 without its valid flag must do nothing
    task noval(input logic [15:0] w);
        do @(negedge clock); while (phase !== 2'h0);
        instr = w;
        instr_valid = 1'b0;
        repeat (3) begin
            @(negedge clock);
            chk(!pc_load && !dm_rd && !dm_wr, "word taken without valid");
        end
    endtask
    task summarize;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #10000;
        failures++;
        summarize;
    end
    initial begin
        repeat (8) @(negedge clock);
        rstn = 1'b1;
        jmp(11'h400, 21'h000100);
        jmp(11'h3ff, 21'h1ffff0);
        jmp(11'h000, 21'h000222);
        run(16'hd955, 21'h000100, 4'h0, 1'b0);
        chk(plv === 3'b000, "bit 11 set taken as jump");
        bset(3'd7, 1'b1, 8'h12, 4'h5, 1'b0, 12'h512);
        bset(3'd0, 1'b0, 8'h5f, 4'h5, 1'b0, 12'h05f);
        bset(3'd2, 1'b0, 8'h60, 4'h5, 1'b0, 12'hf60);
        bset(3'd5, 1'b0, 8'h10, 4'h5, 1'b1, 12'h008);
        bset(3'd6, 1'b0, 8'h60, 4'h5, 1'b1, 12'hf60);
        bset(3'd4, 1'b1, 8'h5f, 4'ha, 1'b1, 12'ha5f);
        noval(16'hd400);
        noval(16'h8123);
        summarize;
    end
endmodule
